// ### shared/qdw_params.svh
// Constants of the quad converter write receiver.
//
// Contract
// - A write opens with address 10011 plus the two address pins and a zero write bit, then one control byte.
// - The control byte picks the action and which of the four channels the data addresses.
// - Control bit 0 set means power-down bytes follow, clear means conversion data follows.
// - In data mode any number of high/low byte pairs is taken and each pair goes to the channel.
// - A data sequence ends only on STOP or repeated START.
// - The low byte carries code bits 3 down to 0 in its upper nibble; its lower nibble is ignored.
// - In power-down mode exactly two bytes follow, the mode bits sitting at bits 7..6 of the first.
// - Channel updates happen at the falling clock edge that ends the acknowledge of the low byte.
// - Load code 00 writes staging only, 01 also loads that channel, 10 loads all, 11 is broadcast.
// - Broadcast with channel bit 1 clear loads all outputs from staging; the address must still match the pins.
`ifndef QDW_PARAMS_SVH
`define QDW_PARAMS_SVH
`define QDW_ADDR_FIXED   5'h13
`define QDW_LOAD_STAGE   2'h0
`define QDW_LOAD_ONE     2'h1
`define QDW_LOAD_ALL     2'h2
`define QDW_LOAD_BCAST   2'h3
`define QDW_CTRL_LOAD_HI 5
`define QDW_CTRL_LOAD_LO 4
`define QDW_CTRL_SEL_HI  2
`define QDW_CTRL_SEL_LO  1
`define QDW_CTRL_KIND    0
`define QDW_PD_HI        7
`define QDW_PD_LO        6
`define QDW_BITS_LAST    3'h7
`define QDW_CODE_RESET   12'h000
`define QDW_PD_RESET     2'h0
`endif

// ### shared/qdw_pkg.sv
// Types of the quad converter write receiver.
package qdw_pkg;
    typedef struct packed {
        logic [1:0]  pd;
        logic [11:0] code;
    } qdw_chan_t;

    typedef enum logic [2:0] {
        QDW_IDLE,
        QDW_ADDR,
        QDW_CTRL,
        QDW_HIGH,
        QDW_LOW,
        QDW_PD_HI,
        QDW_PD_LO,
        QDW_DONE
    } qdw_state_t;
endpackage : qdw_pkg

// ### hdl/qdw_receiver.sv
// Write-side target receiver of a quad 12-bit converter on a two-wire bus.
`timescale 1ns/1ps
`default_nettype none
`include "qdw_params.svh"

module qdw_receiver
    import qdw_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    input  wire logic      sys_clk,
    input  wire logic      srst,
    input  wire logic      ce,
    input  wire logic      scl,
    input  wire logic      sda_in,
    output var  logic      sda_out,
    output var  logic      sda_oe,
    input  wire logic      address_pin_hi,
    input  wire logic      address_pin_lo,
    output var  qdw_chan_t staging_register [CHANNELS],
    output var  qdw_chan_t output_register [CHANNELS],
    output var  logic      update_pulse,
    output var  logic      addressed
);

    // ****************************************
    // Link clock domain
    // ****************************************
    // Each rising clock edge samples the data line and flips a toggle. The sampled bit
    // stays put until the next rising edge, far longer than the toggle takes to cross.
    // Reset acts here at once: the bus clock idles high, so a reset taken through its
    // own edges would swallow the first address bits. It is only released on an idle bus.
    logic link_tgl;
    logic link_bit;

    always_ff @(posedge scl or posedge srst) begin
        if (srst) begin
            link_tgl <= 1'b0;
            link_bit <= 1'b0;
        end else begin
            link_tgl <= ~link_tgl;
            link_bit <= sda_in;
        end
    end

    // ****************************************
    // Synchronisers
    // ****************************************
    logic       scl_m, scl_s, scl_d;
    logic       sda_m, sda_s, sda_d;
    logic       tgl_m, tgl_s, tgl_d;
    logic [1:0] apin_m, apin_s;

    always_ff @(posedge sys_clk) begin
        if (ce) begin
            scl_m  <= scl;
            scl_s  <= scl_m;
            scl_d  <= scl_s;
            sda_m  <= sda_in;
            sda_s  <= sda_m;
            sda_d  <= sda_s;
            tgl_m  <= link_tgl;
            tgl_s  <= tgl_m;
            tgl_d  <= tgl_s;
            apin_m <= {address_pin_hi, address_pin_lo};
            apin_s <= apin_m;
        end
    end

    // ****************************************
    // Bus conditions and decode
    // ****************************************
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    wire scl_fall  = scl_d & ~scl_s;
    wire bit_ev    = tgl_s ^ tgl_d;

    qdw_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] rx;
    logic [7:0] ctrl;
    logic [7:0] hi_byte;
    logic       ack_pend;
    logic       in_ack;

    wire [7:0] next_shift = {shift[6:0], link_bit};
    wire       counting   = (state != QDW_IDLE) && (state != QDW_DONE);
    wire       byte_done  = bit_ev && !in_ack && counting && (bit_cnt == `QDW_BITS_LAST);
    wire       addr_match = (next_shift[7:3] == `QDW_ADDR_FIXED)
                            && (next_shift[2:1] == apin_s) && !next_shift[0];
    wire       ack_ok     = (state == QDW_ADDR) ? addr_match : 1'b1;
    wire       ack_end    = scl_fall && in_ack;

    wire [1:0] load_code = ctrl[`QDW_CTRL_LOAD_HI:`QDW_CTRL_LOAD_LO];
    wire [1:0] sel       = ctrl[`QDW_CTRL_SEL_HI:`QDW_CTRL_SEL_LO];
    wire [1:0] rx_load   = rx[`QDW_CTRL_LOAD_HI:`QDW_CTRL_LOAD_LO];
    wire       rx_bcast  = (rx_load == `QDW_LOAD_BCAST) && !rx[`QDW_CTRL_SEL_HI];

    // Commit of a staging word and the output loads it triggers, all on the ack's end.
    wire commit_data = ack_end && (state == QDW_LOW);
    wire commit_pd   = ack_end && (state == QDW_PD_LO);
    wire commit      = commit_data || commit_pd;
    wire refresh_all = ack_end && (state == QDW_CTRL) && rx_bcast;
    wire new_code_w  = commit_data;

    qdw_chan_t new_word;
    assign new_word.pd   = commit_pd ? hi_byte[`QDW_PD_HI:`QDW_PD_LO] : `QDW_PD_RESET;
    assign new_word.code = {hi_byte, rx[7:4]};

    function automatic logic loads_channel(input logic [1:0] code, input logic is_sel);
        return (code == `QDW_LOAD_ALL) || (code == `QDW_LOAD_BCAST)
               || ((code == `QDW_LOAD_ONE) && is_sel);
    endfunction : loads_channel

    // ****************************************
    // Byte receiver and sequence
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state    <= QDW_IDLE;
            bit_cnt  <= 3'h0;
            shift    <= 8'h00;
            rx       <= 8'h00;
            ctrl     <= 8'h00;
            hi_byte  <= 8'h00;
            ack_pend <= 1'b0;
            in_ack   <= 1'b0;
            sda_oe   <= 1'b0;
            sda_out  <= 1'b0;
        end else if (ce) begin
            if (bus_start) begin
                state    <= QDW_ADDR;
                bit_cnt  <= 3'h0;
                ack_pend <= 1'b0;
                in_ack   <= 1'b0;
                sda_oe   <= 1'b0;
            end else if (bus_stop) begin
                state    <= QDW_IDLE;
                bit_cnt  <= 3'h0;
                ack_pend <= 1'b0;
                in_ack   <= 1'b0;
                sda_oe   <= 1'b0;
            end else begin
                if (bit_ev && !in_ack && counting) begin
                    shift   <= next_shift;
                    bit_cnt <= bit_cnt + 3'h1;
                end
                if (byte_done) begin
                    rx <= next_shift;
                    if (ack_ok) begin
                        ack_pend <= 1'b1;
                    end else begin
                        state <= QDW_IDLE;
                    end
                end
                if (scl_fall && ack_pend) begin
                    ack_pend <= 1'b0;
                    in_ack   <= 1'b1;
                    sda_oe   <= 1'b1;
                end
                if (ack_end) begin
                    in_ack <= 1'b0;
                    sda_oe <= 1'b0;
                    unique case (state)
                        QDW_ADDR: begin
                            state <= QDW_CTRL;
                        end
                        QDW_CTRL: begin
                            ctrl <= rx;
                            if (rx_bcast) begin
                                state <= QDW_DONE;
                            end else if (rx[`QDW_CTRL_KIND]) begin
                                state <= QDW_PD_HI;
                            end else begin
                                state <= QDW_HIGH;
                            end
                        end
                        QDW_HIGH: begin
                            hi_byte <= rx;
                            state   <= QDW_LOW;
                        end
                        QDW_LOW: begin
                            state <= QDW_HIGH;
                        end
                        QDW_PD_HI: begin
                            hi_byte <= rx;
                            state   <= QDW_PD_LO;
                        end
                        QDW_PD_LO: begin
                            state <= QDW_DONE;
                        end
                        QDW_IDLE, QDW_DONE: begin
                            state <= state;
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************
    // Channel registers
    // ****************************************
    // A power-down write keeps the staged code; a data write brings the channel back up.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            wire is_sel   = (sel == 2'(ch));
            wire wr_stage = commit && is_sel;
            wire do_load  = (commit && loads_channel(load_code, is_sel)) || refresh_all;
            qdw_chan_t staged_next;
            assign staged_next.pd   = wr_stage ? new_word.pd : staging_register[ch].pd;
            assign staged_next.code = (wr_stage && new_code_w) ? new_word.code
                                                                : staging_register[ch].code;

            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    staging_register[ch] <= '{pd: `QDW_PD_RESET, code: `QDW_CODE_RESET};
                    output_register[ch]  <= '{pd: `QDW_PD_RESET, code: `QDW_CODE_RESET};
                end else if (ce) begin
                    staging_register[ch] <= staged_next;
                    if (do_load) begin
                        output_register[ch] <= staged_next;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Status
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            update_pulse <= 1'b0;
            addressed    <= 1'b0;
        end else if (ce) begin
            update_pulse <= (commit && (load_code != `QDW_LOAD_STAGE)) || refresh_all;
            addressed    <= (state != QDW_IDLE) && (state != QDW_ADDR);
        end
    end

endmodule : qdw_receiver
`default_nettype wire

// ### bench/qdw_checker.sv
// Assertion checker for the quad converter write receiver.
`timescale 1ns/1ps
`default_nettype none
module qdw_checker
    import qdw_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    input wire logic      sys_clk,
    input wire logic      srst,
    input wire logic      scl,
    input wire logic      sda_in,
    input wire logic      sda_out,
    input wire logic      sda_oe,
    input wire qdw_chan_t staging_register [CHANNELS],
    input wire qdw_chan_t output_register [CHANNELS],
    input wire logic      update_pulse,
    input wire logic      addressed
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ****
    // Bus and update checks. SDA may only move with SCL low, or a false START or STOP appears.
    // ****
    chk_ack_low: assert property (sda_oe |-> !sda_out && !sda_in) else $error("ack not low");
    chk_ack_len: assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("ack short");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl) else $error("sda moved");
    chk_pulse_after: assert property ($changed(output_register[0]) |-> update_pulse)
        else $error("no update pulse");
    chk_pulse_once: assert property (update_pulse |=> !update_pulse) else $error("long pulse");
    chk_out_addr: assert property ($changed(output_register[1]) |-> addressed)
        else $error("load while idle");
    chk_data_pd: assert property ($changed(staging_register[0].code)
        |-> staging_register[0].pd == 2'h0) else $error("data kept pd");
    chk_stop_end: assert property (scl && $past(scl) && $rose(sda_in) |-> ##[1:8] !addressed)
        else $error("stop ignored");
    chk_start_end: assert property (scl && $past(scl) && $fell(sda_in) |-> ##[1:8] !addressed)
        else $error("start ignored");
    cov_update: cover property (update_pulse);
    cov_addr: cover property ($rose(addressed));
    cov_ack: cover property ($rose(sda_oe));
endmodule : qdw_checker
bind qdw_receiver qdw_checker #(.CHANNELS(CHANNELS)) i_chk (.sys_clk, .srst, .scl, .sda_in,
    .sda_out, .sda_oe, .staging_register, .output_register, .update_pulse, .addressed);
`default_nettype wire

// ### bench/qdw_master.sv
// Two-wire bus master model that sends write frames.
`timescale 1ns/1ps
`default_nettype none
module qdw_master (
    output var logic scl,
    output var logic sda_pull,
    input  wire logic sda
);
    // ****
    // Bus phases. Q waits out the device's ack release before SDA moves again.
    // ****
    localparam realtime H = 515.0;
    localparam realtime Q = 300.0;
    // The clock comes up low and is released once, so the device sees a rising edge
    // while it is still held in reset.
    initial begin
        scl = 1'b0;
        sda_pull = 1'b0;
        #Q scl = 1'b1;
    end
    task automatic start;
        #Q sda_pull = 1'b0;
        #Q scl = 1'b1;
        #H sda_pull = 1'b1;
        #H scl = 1'b0;
    endtask : start
    task automatic stop;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b1;
        #H sda_pull = 1'b0;
        #H;
    endtask : stop
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #Q sda_pull = !b[i];
            #H scl = 1'b1;
            #H scl = 1'b0;
        end
        #Q sda_pull = 1'b0;
        #H scl = 1'b1;
        ack = !sda;
        #H scl = 1'b0;
    endtask : send
endmodule : qdw_master
`default_nettype wire

// ### bench/test_quad_dac_i2c_write_receiver.sv
// Self-checking bench for the quad converter write receiver.
`timescale 1ns/1ps
`default_nettype none
`include "qdw_params.svh"
module test_quad_dac_i2c_write_receiver
    import qdw_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic       scl, pull, pin_hi, pin_lo, upd, adr, oe, so;
    wire logic  sda;
    qdw_chan_t  stg [4], outr [4], e_stg [4], e_out [4];
    int         error_cnt, tests_run;
    int         upd_cnt, e_upd;
    logic [7:0] dev;
    always #25 sys_clk = ~sys_clk;
    assign sda = !(pull || (oe && !so));
    qdw_receiver i_dut (.sys_clk, .srst, .ce(1'b1), .scl, .sda_in(sda), .sda_out(so),
        .sda_oe(oe), .address_pin_hi(pin_hi), .address_pin_lo(pin_lo),
        .staging_register(stg), .output_register(outr), .update_pulse(upd), .addressed(adr));
    qdw_master i_mst (.scl, .sda_pull(pull), .sda);
    always @(negedge sys_clk) begin
        if (upd === 1'b1) upd_cnt++;
    end
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic frame(input logic [7:0] b [$], input int n);
        logic ack;
        i_mst.start();
        foreach (b[i]) begin
            i_mst.send(b[i], ack);
            check(ack, i < n);
        end
        repeat (8) @(negedge sys_clk);
        check(adr, n > 0);
    endtask : frame
    task automatic commit(input logic [7:0] c, input logic [11:0] v);
        logic [1:0] s;
        s = c[2:1];
        if (c[0]) e_stg[s].pd = v[11:10];
        else e_stg[s] = {2'h0, v};
        if (c[5:4] == 2'h1) e_out[s] = e_stg[s];
        if (c[5:4] >= 2'h2) e_out = e_stg;
        if (c[5:4] != 2'h0) e_upd++;
    endtask : commit
    task automatic fin(input string t);
        i_mst.stop();
        repeat (10) @(negedge sys_clk);
        check(adr, 1'b0);
        check(14'(upd_cnt), 14'(e_upd));
        for (int c = 0; c < 4; c++) begin
            check(stg[c], e_stg[c]);
            check(outr[c], e_out[c]);
        end
        $display("test %s done", t);
    endtask : fin
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
    initial begin
        error_cnt = 0;
        tests_run = 0;
        pin_hi = 1'b1;
        pin_lo = 1'b0;
        e_stg = '{default: '0};
        e_out = e_stg;
        dev = {`QDW_ADDR_FIXED, 2'h2, 1'b0};
        repeat (10) @(negedge sys_clk);
        srst = 1'b0;
        repeat (5) @(negedge sys_clk);
        // Every pair of a run is committed in turn; low nibble of a low byte is ignored.
        frame('{dev, 8'h10, 8'hAB, 8'hCF, 8'h12, 8'h3F}, 6);
        commit(8'h10, 12'hABC);
        commit(8'h10, 12'h123);
        fin("pairs");
        for (int c = 0; c < 4; c++) begin
            frame('{dev, 8'(c << 1), 8'(8'h40 + c), 8'h50}, 4);
            commit(8'(c << 1), {8'(8'h40 + c), 4'h5});
        end
        frame('{dev, 8'h22, 8'h77, 8'h80}, 4);
        commit(8'h22, 12'h778);
        frame('{dev, 8'h34, 8'h99, 8'hA0}, 4);
        commit(8'h34, 12'h99A);
        fin("loads");
        frame('{dev, 8'h17, 8'hC0, 8'h05, 8'hFF}, 4);
        commit(8'h17, 12'hC00);
        fin("powerdown");
        frame('{dev, 8'h00, 8'h5A, 8'h50}, 4);
        commit(8'h00, 12'h5A5);
        frame('{dev, 8'h30, 8'h11, 8'h22}, 2);
        e_out = e_stg;
        e_upd++;
        fin("broadcast");
        pin_lo = 1'b1;
        repeat (5) @(negedge sys_clk);
        frame('{dev, 8'h10, 8'hFF, 8'hF0}, 0);
        pin_lo = 1'b0;
        repeat (5) @(negedge sys_clk);
        frame('{dev | 8'h01, 8'h10, 8'hFF, 8'hF0}, 0);
        fin("address");
        // A half pair cut off by STOP must leave every word untouched.
        frame('{dev, 8'h10, 8'hEE}, 3);
        fin("abort");
        summarize();
    end
endmodule : test_quad_dac_i2c_write_receiver
`default_nettype wire
